// *** logic/ppm_port_mux.sv ***
// port pin multiplexer: four port latches with alternate function sharing
`timescale 1ns/1ns
//
// Behaviour
// - a latched one releases the pin (output enable off), a latched zero holds it low
// - four bidirectional ports, each with latch, driver and input buffer
// - port zero carries low address while address strobe high, then data
// - port two carries the upper address byte during external accesses
// - external memory role enabled when the external access pin is low
// - port three bit one is shared data pin, or transmit only in loop mode
// - storing zero in port three bit one latch enters diagnostic mode
// - port three bits two and three are interrupt and counter gate inputs
// - port three bits four and five are counter inputs when timer settings select
// - port three bit five may clock the serial unit externally
// - port three bit six gives active-low write strobe on external data writes
// - port three bit seven gives active-low read strobe on external data reads
// - port one bit six drives active-low request, bit seven takes clear input
// - port zero drivers are open drain without pullups as port I/O, but drive both levels for address and write data
// - ports one to three have internal pullups, so a one is a weak high
module ppm_port_mux (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // cpu special function register access
  input  wire ppm_pkg::ppm_sfr_t    sfr,
  output logic [7:0]                sfr_rdata,
  // external memory cycle and strap
  input  wire ppm_pkg::ppm_mem_t    mem,
  input  wire logic                 ext_access_sel_n,
  output logic                      addr_strobe,
  output logic [7:0]                mem_rdata,
  // serial unit and timer configuration
  input  wire ppm_pkg::ppm_ser_t    ser,
  input  wire logic                 loop_mode_select,
  input  wire logic                 cnt0_sel,
  input  wire logic                 cnt1_sel,
  output ppm_pkg::ppm_alt_in_t      alt_in,
  // pins of the four ports
  input  wire logic [7:0]           port_zero_in,
  input  wire logic [7:0]           port_one_in,
  input  wire logic [7:0]           port_two_in,
  input  wire logic [7:0]           port_three_in,
  output ppm_pkg::ppm_pin_t         port_zero,
  output ppm_pkg::ppm_pin_t         port_one,
  output ppm_pkg::ppm_pin_t         port_two,
  output ppm_pkg::ppm_pin_t         port_three,
  // pullup enables for ports one to three
  output logic [7:0]                port_one_pu,
  output logic [7:0]                port_two_pu,
  output logic [7:0]                port_three_pu
);
  import ppm_pkg::*;

  // open-drain / pullup driver: drive low only, or drive high weakly via pullup
  function automatic ppm_pin_t od_drive(input logic [7:0] val);
    ppm_pin_t p;
    p.out = 8'h00;
    p.oe  = ~val; // one released to the pullup or external resistor
    return p;
  endfunction : od_drive

  // alternate active-low output merged with its latch bit: a latched zero always wins
  function automatic logic alt_low(input logic latch_bit, input logic active);
    return latch_bit & ~active;
  endfunction : alt_low

  // latch storage and registered pin state
  logic [7:0]  latch_ff [4];
  logic [7:0]  nxt_latch [4];
  ppm_pin_t    p0_ff, p1_ff, p2_ff, p3_ff;
  ppm_pin_t    nxt_p0, nxt_p1, nxt_p2, nxt_p3;
  ppm_alt_in_t alt_ff, nxt_alt;
  logic [7:0]  rdata_ff, nxt_rdata;
  logic [7:0]  mrd_ff, nxt_mrd;
  logic        ale_ff, nxt_ale;
  logic        ext_mem;
  logic        diag;
  logic [1:0]  sel;
  logic        hit;
  logic [7:0]  pu1_ff, pu2_ff, pu3_ff;
  logic [7:0]  nxt_pu1, nxt_pu2, nxt_pu3;
  logic        mem_addr;
  logic        mem_wdrv;
  logic        mem_rdrv;
  logic        mem_wstb;
  logic        mem_busy;

  assign ext_mem = ~ext_access_sel_n;
  assign diag    = ~latch_ff[3][P3_DATA];

  // memory phases only count while the strap selects the external role
  assign mem_addr = ext_mem && mem.addr_phase;
  assign mem_wdrv = ext_mem && mem.data_out;
  assign mem_rdrv = ext_mem && mem.rd_strobe;
  assign mem_wstb = ext_mem && mem.wr_strobe;
  assign mem_busy = mem_addr || mem_wdrv || mem_rdrv || mem_wstb;

  // address decode of the four port latches
  always_comb begin
    sel = 2'd0;
    hit = 1'b1;
    unique case (sfr.addr)
      ADDR_PORT0: sel = 2'd0;
      ADDR_PORT1: sel = 2'd1;
      ADDR_PORT2: sel = 2'd2;
      ADDR_PORT3: sel = 2'd3;
      default:    hit = 1'b0;
    endcase
  end

  // latch writes and register reads (reads return pin levels)
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      nxt_latch[i] = latch_ff[i];
    end
    if (sfr.wr && hit) begin
      nxt_latch[sel] = sfr.wdata;
    end
    nxt_rdata = rdata_ff;
    if (sfr.rd) begin
      unique case ({hit, sel})
        3'b100:  nxt_rdata = port_zero_in;
        3'b101:  nxt_rdata = port_one_in;
        3'b110:  nxt_rdata = port_two_in;
        3'b111:  nxt_rdata = port_three_in;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // port zero and port two drive, with external memory override
  always_comb begin
    nxt_ale = mem_addr;
    nxt_mrd = mrd_ff;
    nxt_p0  = od_drive(latch_ff[0]);
    nxt_p2  = od_drive(latch_ff[2]);
    if (mem_addr) begin
      nxt_p0.out = mem.addr[7:0];
      nxt_p0.oe  = 8'hFF;
    end else if (mem_wdrv) begin
      nxt_p0.out = mem.wdata;
      nxt_p0.oe  = 8'hFF;
    end else if (mem_rdrv) begin
      nxt_p0.oe  = 8'h00;                        // release bus for read data
      nxt_mrd    = port_zero_in;
    end
    // the high address byte stands for the whole external cycle
    if (mem_busy) begin
      nxt_p2.out = mem.addr[15:8];
      nxt_p2.oe  = 8'hFF;
    end
  end

  // port one: latch drive with request-to-send gated in
  always_comb begin
    logic [7:0] v;
    v = latch_ff[1];
    v[P1_RTSN] = alt_low(latch_ff[1][P1_RTSN], ser.rts);
    nxt_p1 = od_drive(v);
  end

  // port three: serial pins and memory strobes combined with latch
  always_comb begin
    logic [7:0] v;
    v = latch_ff[3];
    if (!loop_mode_select && !diag) begin
      v[P3_DIR] = latch_ff[3][P3_DIR] & ser.dir;
    end
    v[P3_WRN] = alt_low(latch_ff[3][P3_WRN], mem_wstb);
    v[P3_RDN] = alt_low(latch_ff[3][P3_RDN], mem_rdrv);
    nxt_p3 = od_drive(v);
    // outside diagnostic mode, loop mode transmits all the time; shared mode only while the serial unit sends
    if (!diag && (loop_mode_select || ser.tx_oe)) begin
      nxt_p3.out[P3_DATA] = ser.tx_data;
      nxt_p3.oe[P3_DATA]  = 1'b1;
    end
    if (!diag && !loop_mode_select && !ser.tx_oe) begin
      nxt_p3.oe[P3_DATA] = 1'b0;
    end
  end

  // alternate inputs to interrupts, timers and serial unit
  always_comb begin
    nxt_alt.irq0    = port_three_in[P3_IRQ0];
    nxt_alt.irq1    = port_three_in[P3_IRQ1];
    nxt_alt.cnt0    = cnt0_sel & port_three_in[P3_CNT0];
    nxt_alt.cnt1    = cnt1_sel & port_three_in[P3_CNT1];
    nxt_alt.sclk    = port_three_in[P3_CNT1];
    nxt_alt.rx_data = (loop_mode_select || diag) ? port_three_in[P3_DIR]
                                                 : port_three_in[P3_DATA];
    nxt_alt.cts     = port_one_in[P1_CTSN];
    nxt_alt.diag    = diag;
  end

  // pullups are fixed structure; a register keeps the outputs on flip-flops
  always_comb begin
    nxt_pu1 = PULLUP_ON;
    nxt_pu2 = PULLUP_ON;
    nxt_pu3 = PULLUP_ON;
  end

  // latch and read data registers; latches reset to ones
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 4; i++) begin
        latch_ff[i] <= LATCH_RST;
      end
      rdata_ff <= 8'h00;
    end else begin
      for (int i = 0; i < 4; i++) begin
        latch_ff[i] <= nxt_latch[i];
      end
      rdata_ff <= nxt_rdata;
    end
  end

  // external memory registers: ports zero and two, address strobe, read capture
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      p0_ff  <= '0;
      p2_ff  <= '0;
      mrd_ff <= 8'h00;
      ale_ff <= 1'b0;
    end else begin
      p0_ff  <= nxt_p0;
      p2_ff  <= nxt_p2;
      mrd_ff <= nxt_mrd;
      ale_ff <= nxt_ale;
    end
  end

  // port one pin register; released in reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      p1_ff <= '0;
    end else begin
      p1_ff <= nxt_p1;
    end
  end

  // port three pin register; released in reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      p3_ff <= '0;
    end else begin
      p3_ff <= nxt_p3;
    end
  end

  // alternate input register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      alt_ff <= '0;
    end else begin
      alt_ff <= nxt_alt;
    end
  end

  // pullup enable register: pullups stay on through reset so released pins read high
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pu1_ff <= PULLUP_ON;
      pu2_ff <= PULLUP_ON;
      pu3_ff <= PULLUP_ON;
    end else begin
      pu1_ff <= nxt_pu1;
      pu2_ff <= nxt_pu2;
      pu3_ff <= nxt_pu3;
    end
  end

  // outputs straight from flip-flops
  assign port_zero     = p0_ff;
  assign port_one      = p1_ff;
  assign port_two      = p2_ff;
  assign port_three    = p3_ff;
  assign alt_in        = alt_ff;
  assign sfr_rdata     = rdata_ff;
  assign mem_rdata     = mrd_ff;
  assign addr_strobe   = ale_ff;
  assign port_one_pu   = pu1_ff;
  assign port_two_pu   = pu2_ff;
  assign port_three_pu = pu3_ff;
endmodule : ppm_port_mux

// *** common/ppm_pkg.sv ***
// package for the port pin multiplexer: register map, reset values and carrier types
package ppm_pkg;
  // special function register byte addresses
  localparam logic [7:0] ADDR_PORT0 = 8'h80;
  localparam logic [7:0] ADDR_PORT1 = 8'h90;
  localparam logic [7:0] ADDR_PORT2 = 8'hA0;
  localparam logic [7:0] ADDR_PORT3 = 8'hB0;
  // latch reset value: all ones so pins float high and alternate functions pass
  localparam logic [7:0] LATCH_RST  = 8'hFF;
  // pullup enable value: every pullup of ports one to three switched on
  localparam logic [7:0] PULLUP_ON  = 8'hFF;
  // port three bit positions
  localparam int P3_DIR   = 0;
  localparam int P3_DATA  = 1;
  localparam int P3_IRQ0  = 2;
  localparam int P3_IRQ1  = 3;
  localparam int P3_CNT0  = 4;
  localparam int P3_CNT1  = 5;
  localparam int P3_WRN   = 6;
  localparam int P3_RDN   = 7;
  // port one bit positions
  localparam int P1_RTSN  = 6;
  localparam int P1_CTSN  = 7;
  // one port's pin drive: output value and output enable
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } ppm_pin_t;
  // cpu special function register access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ppm_sfr_t;
  // external memory cycle request from the cpu core
  typedef struct packed {
    logic        addr_phase;
    logic        data_out;
    logic        wr_strobe;
    logic        rd_strobe;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ppm_mem_t;
  // serial unit and modem side alternate signals
  typedef struct packed {
    logic dir;
    logic tx_data;
    logic tx_oe;
    logic rts;
  } ppm_ser_t;
  // alternate inputs handed to timers, interrupts and serial unit
  typedef struct packed {
    logic irq0;
    logic irq1;
    logic cnt0;
    logic cnt1;
    logic sclk;
    logic rx_data;
    logic cts;
    logic diag;
  } ppm_alt_in_t;
endpackage : ppm_pkg

// *** sim/ppm_port_mux_sva.sv ***
// assertion checker for the port pin multiplexer
`timescale 1ns/1ns
module ppm_port_mux_sva (
  // clock, reset and cpu side
  input logic              clk,
  input logic              rstn,
  input ppm_pkg::ppm_sfr_t sfr,
  input logic [7:0]        sfr_rdata,
  // memory and serial side
  input ppm_pkg::ppm_mem_t mem,
  input logic              ext_access_sel_n,
  input logic              addr_strobe,
  input ppm_pkg::ppm_ser_t ser,
  // pins
  input logic [7:0]        port_one_in,
  input ppm_pkg::ppm_pin_t port_zero,
  input ppm_pkg::ppm_pin_t port_one,
  input ppm_pkg::ppm_pin_t port_two,
  input ppm_pkg::ppm_pin_t port_three
);
  import ppm_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // latch stores and reads of pin levels
  a_latch_pin: assert property (sfr.wr && sfr.addr == ADDR_PORT1
    |-> ##2 port_one.oe[5:0] == ~$past(sfr.wdata[5:0], 2)) else $error("pins miss latch");
  a_read_pins: assert property (sfr.rd && sfr.addr == ADDR_PORT1
    |=> sfr_rdata == $past(port_one_in)) else $error("read data wrong");
  // external memory bus on ports zero and two
  a_low_addr: assert property (!ext_access_sel_n && mem.addr_phase
    |=> addr_strobe && port_zero.oe == 8'hFF && port_zero.out == $past(mem.addr[7:0])) else $error("low addr");
  a_high_addr: assert property (!ext_access_sel_n && mem.addr_phase
    |=> port_two.out == $past(mem.addr[15:8])) else $error("high addr");
  a_strap_off: assert property (ext_access_sel_n |=> !addr_strobe)
    else $error("strobe without strap");
  // strobes and modem request drive low
  a_write_strobe: assert property (!ext_access_sel_n && mem.wr_strobe
    |=> port_three.oe[6] && !port_three.out[6]) else $error("write strobe");
  a_read_strobe: assert property (!ext_access_sel_n && mem.rd_strobe
    |=> port_three.oe[7] && !port_three.out[7]) else $error("read strobe");
  a_rts_drive: assert property (ser.rts |=> port_one.oe[6] && !port_one.out[6])
    else $error("request not driven");
endmodule : ppm_port_mux_sva
bind ppm_port_mux ppm_port_mux_sva u_sva (.*);

// *** sim/ppm_pin_model.sv ***
// pin model: board pullups, external memory, modem and pin drivers
`timescale 1ns/1ns
module ppm_pin_model (
  // design pin drive
  input ppm_pkg::ppm_pin_t port_zero,
  input ppm_pkg::ppm_pin_t port_one,
  input ppm_pkg::ppm_pin_t port_two,
  input ppm_pkg::ppm_pin_t port_three,
  input logic [7:0]        port_one_pu,
  input logic [7:0]        port_two_pu,
  input logic [7:0]        port_three_pu,
  // far side drive
  input logic [7:0]        rd_byte,
  input logic [7:0]        p3_drv,
  input logic              cts_n,
  // resolved levels
  output logic [7:0]       port_zero_in,
  output logic [7:0]       port_one_in,
  output logic [7:0]       port_two_in,
  output logic [7:0]       port_three_in
);
  import ppm_pkg::*;
  // released bit takes far drive, else pullup, else inverse of last value
  function automatic logic [7:0] lvl(ppm_pin_t p, logic [7:0] e, d, pu);
    return p.oe & p.out | ~p.oe & (e & d | ~e & (pu | ~p.out));
  endfunction : lvl
  // memory answers while read strobe pin is low, board pullup otherwise
  assign port_zero_in  = lvl(port_zero, 8'hFF,
    (port_three.oe[7] && !port_three.out[7]) ? rd_byte : 8'hFF, 8'h00);
  assign port_one_in   = lvl(port_one, 8'h80, {cts_n, 7'h00}, port_one_pu);
  assign port_two_in   = lvl(port_two, 8'h00, 8'h00, port_two_pu);
  assign port_three_in = lvl(port_three, 8'h3C, p3_drv, port_three_pu);
endmodule : ppm_pin_model

// *** sim/ppm_port_mux_test.sv ***
// self-checking testbench for the port pin multiplexer
`timescale 1ns/1ns
module ppm_port_mux_test;
  import ppm_pkg::*;
  logic clk, rstn, ext_access_sel_n, addr_strobe, loop_mode_select, cnt0_sel, cnt1_sel, cts_n;
  logic [7:0] sfr_rdata, mem_rdata, rd_byte, p3_drv, port_zero_in, port_one_in, port_two_in, port_three_in;
  logic [7:0] port_one_pu, port_two_pu, port_three_pu;
  ppm_sfr_t sfr;
  ppm_mem_t mem;
  ppm_ser_t ser;
  ppm_alt_in_t alt_in;
  ppm_pin_t port_zero, port_one, port_two, port_three;
  int fail_count, num_checks;
  logic [7:0] adr [5] = '{ADDR_PORT0, ADDR_PORT1, ADDR_PORT2, ADDR_PORT3, 8'hC0};
  logic [7:0] val [5] = '{8'h5A, 8'hA5, 8'h3C, 8'hC3, 8'h77};
  logic [7:0] msk [5] = '{8'hFF, 8'hFF, 8'hFF, 8'hFC, 8'hFF};
  logic [7:0] want [5] = '{8'h5A, 8'hA5, 8'h3C, 8'hC0, 8'h00};
  // design and far side
  ppm_port_mux DUT (.*);
  ppm_pin_model u_pins (.*);
  // clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // compare and count
  task automatic chk(input logic [7:0] s, e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, s, e);
    end
  endtask : chk
  // one register write or read
  task automatic sfr_op(input logic w, input logic [7:0] a, d);
    @(posedge clk) sfr <= '{w, !w, a, d};
    @(posedge clk) sfr <= '0;
    @(posedge clk) #1;
  endtask : sfr_op
  task automatic end_of_test;
    if (fail_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  // hang guard
  initial begin
    #20000;
    fail_count++;
    end_of_test;
  end
  // test sequence
  initial begin
    rstn = 1'b0; sfr = '0; mem = '0; ser = '0; ext_access_sel_n = 1'b1; loop_mode_select = 1'b0;
    cnt0_sel = 1'b1; cnt1_sel = 1'b1; cts_n = 1'b1; rd_byte = 8'h91; p3_drv = 8'h00;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    sfr_op(1'b0, ADDR_PORT1, 8'h00);
    chk(sfr_rdata, LATCH_RST);
    for (int i = 0; i < 5; i++) begin
      sfr_op(1'b1, adr[i], val[i]);
      sfr_op(1'b0, adr[i], 8'h00);
      chk(sfr_rdata & msk[i], want[i]);
    end
    sfr_op(1'b1, ADDR_PORT3, 8'hFD);
    @(posedge clk) #1 chk(alt_in.diag, 1'b1);
    sfr_op(1'b1, ADDR_PORT3, 8'hFF);
    @(posedge clk) #1 chk(alt_in.diag, 1'b0);
    @(posedge clk) begin p3_drv <= 8'h34; cts_n <= 1'b0; end
    repeat (2) @(posedge clk); #1;
    chk({alt_in.irq0, alt_in.irq1, alt_in.cnt0, alt_in.cnt1, alt_in.sclk, alt_in.cts}, 6'b101110);
    @(posedge clk) begin ser <= '{1'b1, 1'b0, 1'b0, 1'b0}; loop_mode_select <= 1'b1; cnt0_sel <= 1'b0; end
    repeat (2) @(posedge clk); #1;
    chk(port_three_in[1:0], 2'b01);
    chk(alt_in.rx_data, 1'b1);
    chk(alt_in.cnt0, 1'b0);
    @(posedge clk) begin ser <= '{1'b1, 1'b0, 1'b1, 1'b0}; loop_mode_select <= 1'b0; end
    repeat (2) @(posedge clk); #1;
    chk(alt_in.rx_data, 1'b0);
    chk(port_one_pu & port_two_pu & port_three_pu, 8'hFF);
    sfr_op(1'b1, ADDR_PORT1, 8'hFF);
    @(posedge clk) begin ser <= '{1'b0, 1'b0, 1'b0, 1'b1}; cts_n <= 1'b1; cnt0_sel <= 1'b1; end
    sfr_op(1'b0, ADDR_PORT1, 8'h00);
    chk(sfr_rdata, 8'hBF);
    @(posedge clk) begin ser <= '0; mem <= '{1'b1, 1'b0, 1'b0, 1'b0, 16'h12A7, 8'h00}; end
    @(posedge clk) #1 chk(addr_strobe, 1'b0);
    @(posedge clk) ext_access_sel_n <= 1'b0;
    @(posedge clk) #1 chk(addr_strobe, 1'b1);
    chk(port_two.out, 8'h12);
    chk(port_zero_in, 8'hA7);
    @(posedge clk) mem <= '{1'b0, 1'b1, 1'b1, 1'b0, 16'h12A7, 8'h6E};
    @(posedge clk) #1 chk(port_zero_in, 8'h6E);
    chk(port_three_in[7:6], 2'b10);
    @(posedge clk) mem <= '{1'b0, 1'b0, 1'b0, 1'b1, 16'h12A7, 8'h00};
    repeat (2) @(posedge clk); #1;
    chk(mem_rdata, 8'h91);
    @(posedge clk) begin mem <= '0; ext_access_sel_n <= 1'b1; end
    repeat (2) @(posedge clk);
    end_of_test;
  end
endmodule : ppm_port_mux_test
